/* include/synth_prog_pkg.sv */
package synth_prog_pkg;
  // Word layout
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_FEEDBACK = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  // Control word fields
  localparam int CTL_PRESCALE_LSB = 22;
  localparam int CTL_PD_MODE_BIT = 21;
  localparam int CTL_PD_REQ_BIT = 20;
  localparam int CTL_CP2_LSB = 17;
  localparam int CTL_CP1_LSB = 14;
  localparam int CTL_OUT_LEVEL_LSB = 12;
  localparam int CTL_MUTE_BIT = 11;
  localparam int CTL_GAIN_BIT = 10;
  localparam int CTL_TRISTATE_BIT = 9;
  localparam int CTL_POLARITY_BIT = 8;
  localparam int CTL_MUX_LSB = 5;
  localparam int CTL_CLEAR_BIT = 4;
  localparam int CTL_CORE_LSB = 2;
  // Feedback word fields
  localparam int FB_HALVED_IN_BIT = 23;
  localparam int FB_HALVING_BIT = 22;
  localparam int FB_GAIN_BIT = 21;
  localparam int FB_MAIN_LSB = 8;
  localparam int FB_MAIN_W = 13;
  localparam int FB_RSV_BIT = 7;
  localparam int FB_SWALLOW_LSB = 2;
  localparam int FB_SWALLOW_W = 5;
  // Reference word fields
  localparam int REF_RSV_LSB = 22;
  localparam int REF_BAND_DIV_LSB = 20;
  localparam int REF_TEST_BIT = 19;
  localparam int REF_LDP_BIT = 18;
  localparam int REF_ABP_LSB = 16;
  localparam int REF_COUNT_LSB = 2;
  localparam int REF_COUNT_W = 14;
  // Reset values of held words
  localparam logic [23:0] WORD_RESET = 24'h000000;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int SCLK_DIV = 4;
  localparam int SETTLE_LONG_US = 10000;
  localparam int SETTLE_SHORT_US = 600;
  localparam int SETTLE_LONG_CYC = SETTLE_LONG_US * CLK_MHZ;
  localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_US * CLK_MHZ;
  // Host registers on AHB-Lite
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF = 8'h04;
  localparam logic [7:0] ADDR_CTL = 8'h08;
  localparam logic [7:0] ADDR_FB = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // CTRL bits
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SHORT_BIT = 1;
  localparam int CTRL_CHIP_EN_BIT = 2;
  localparam int CTRL_FB_ONLY_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h4;
endpackage

/* include/synth_link_if.sv */
`timescale 1ns/1ps
interface synth_link_if;
  logic serial_clk;
  logic serial_data;
  logic load_enable;
  logic chip_enable;
  modport host (output serial_clk, output serial_data, output load_enable, output chip_enable);
  modport device (input serial_clk, input serial_data, input load_enable, input chip_enable);
endinterface

/* hw/synth_latch_device.sv */
`timescale 1ns/1ps
module synth_latch_device
  import synth_prog_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Link
  synth_link_if.device LINK,
  // Held words
  output logic [23:0] O_CONTROL_WORD,
  output logic [23:0] O_REFERENCE_WORD,
  output logic [23:0] O_FEEDBACK_WORD,
  // Decoded state
  output logic O_POWERED,
  output logic O_PUMP_GAIN,
  output logic O_BAND_SELECT
);
  logic [23:0] shift;
  logic sclk_q;
  logic le_q;
  logic ever_ctl;
  logic pd_fb_changed;
  logic gain;
  wire sclk_rise = LINK.serial_clk & ~sclk_q;
  wire le_rise = LINK.load_enable & ~le_q;
  wire [1:0] sel = shift[1:0];
  wire pd_now = ~LINK.chip_enable | O_CONTROL_WORD[CTL_PD_REQ_BIT];

  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
    begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
    end
    else
    begin
      sclk_q <= LINK.serial_clk;
      le_q <= LINK.load_enable;
    end

  // R15 msb first shift
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      shift <= WORD_RESET;
    else if (sclk_rise)
      shift <= {shift[22:0], LINK.serial_data};

  // R16 R19 load selected latch
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
    begin
      O_CONTROL_WORD <= WORD_RESET;
      O_REFERENCE_WORD <= WORD_RESET;
      O_FEEDBACK_WORD <= WORD_RESET;
    end
    else if (le_rise)
    begin
      // R1 control target
      if (sel == SEL_CONTROL)
        O_CONTROL_WORD <= shift;
      // R8 reference target
      if (sel == SEL_REFERENCE)
        O_REFERENCE_WORD <= shift;
      // R6 feedback target
      if (sel == SEL_FEEDBACK)
        O_FEEDBACK_WORD <= shift;
    end

  // R5 R4 shared gain latest
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      gain <= 1'b0;
    else if (le_rise && sel == SEL_CONTROL)
      gain <= shift[CTL_GAIN_BIT];
    else if (le_rise && sel == SEL_FEEDBACK)
      gain <= shift[FB_GAIN_BIT];

  // R10 control write powers up
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      ever_ctl <= 1'b0;
    else if (le_rise && sel == SEL_CONTROL)
      ever_ctl <= 1'b1;

  // R13 R14 band kept unless feedback changed
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      pd_fb_changed <= 1'b0;
    else if (le_rise && sel == SEL_FEEDBACK && pd_now)
      pd_fb_changed <= 1'b1;
    else if (le_rise && sel == SEL_FEEDBACK)
      pd_fb_changed <= 1'b0;

  // Band search on feedback load, not on mere power-up
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      O_BAND_SELECT <= 1'b0;
    else
      O_BAND_SELECT <= le_rise && sel == SEL_FEEDBACK && !pd_now;

  // R2 R10 power-down bit and chip enable decoded by name
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      O_POWERED <= 1'b0;
    else
      O_POWERED <= ever_ctl & ~pd_now & ~pd_fb_changed;

  assign O_PUMP_GAIN = gain;
endmodule

/* hw/synth_latch_host.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - Select bits 00 load control latch
// R2 - Control holds prescaler and power-down bits
// R3 - Control holds pump currents, output level
// R4 - Control holds mute, gain, polarity, mux
// R5 - Feedback holds halving and gain bits
// R6 - Select bits 10 load feedback latch
// R7 - Reference holds band clock, test, precision
// R8 - Select bits 01 load reference latch
// R9 - Write reference, control, then feedback
// R10 - Control write powers up device
// R11 - Wait settle interval before feedback
// R12 - Feedback changed in power-down needs resequence
// R13 - Chip-enable cycle keeps band
// R14 - Software power cycle keeps band
// R15 - Shift 24 bits msb first
// R16 - Load-enable rise copies to latch
// R17 - Never send select bits 11
// R18 - Reserved and test bits sent zero
// R19 - Latches hold until reloaded
module synth_latch_host
  import synth_prog_pkg::*;
#(
  parameter int SETTLE_LONG = SETTLE_LONG_CYC,
  parameter int SETTLE_SHORT = SETTLE_SHORT_CYC
)
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [7:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Link
  synth_link_if.host LINK
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_LOAD = 6'b000010,
    S_SHIFT = 6'b000100,
    S_LATCH = 6'b001000,
    S_WAIT = 6'b010000,
    S_NEXT = 6'b100000
  } state_t;

  state_t state;
  logic [3:0] ctrl;
  logic [23:0] ref_w;
  logic [23:0] ctl_w;
  logic [23:0] fb_w;
  logic [23:0] out_sh;
  logic [4:0] bit_cnt;
  logic [1:0] step;
  logic [31:0] wait_cnt;
  logic [3:0] div_cnt;
  logic sclk;
  logic sdat;
  logic le;
  logic fb_dirty;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic busy;
  wire tick = (div_cnt == 4'(SCLK_DIV - 1));
  wire addr_ok = I_HSEL & I_HREADY & I_HTRANS[1];

  function automatic logic [23:0] sanitize(input logic [23:0] w, input logic [1:0] s);
    logic [23:0] r;
    r = w;
    r[1:0] = s;
    // R18 reserved and test zero
    if (s == SEL_FEEDBACK)
      r[FB_RSV_BIT] = 1'b0;
    if (s == SEL_REFERENCE)
    begin
      r[23:REF_RSV_LSB] = 2'h0;
      r[REF_TEST_BIT] = 1'b0;
    end
    return r;
  endfunction

  // R9 fixed write order
  function automatic logic [23:0] pick(input logic [1:0] n);
    logic [23:0] r;
    r = WORD_RESET;
    unique case (n)
      2'h0: r = sanitize(ref_w, SEL_REFERENCE);
      2'h1: r = sanitize(ctl_w, SEL_CONTROL);
      default: r = sanitize(fb_w, SEL_FEEDBACK);
    endcase
    return r;
  endfunction

  // Bus: zero wait states, writes land in data phase
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      O_HRDATA <= 32'h00000000;
    end
    else
    begin
      wr_pend <= addr_ok & I_HWRITE;
      wr_addr <= I_HADDR;
      if (addr_ok && !I_HWRITE)
        unique case (I_HADDR)
          ADDR_CTRL: O_HRDATA <= {28'h0, ctrl};
          ADDR_REF: O_HRDATA <= {8'h00, ref_w};
          ADDR_CTL: O_HRDATA <= {8'h00, ctl_w};
          ADDR_FB: O_HRDATA <= {8'h00, fb_w};
          ADDR_STATUS: O_HRDATA <= {30'h0, fb_dirty, busy};
          default: O_HRDATA <= 32'h00000000;
        endcase
    end
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
    begin
      ctrl <= CTRL_RESET;
      ref_w <= WORD_RESET;
      ctl_w <= WORD_RESET;
      fb_w <= WORD_RESET;
    end
    else
    begin
      if (state == S_IDLE)
        ctrl[CTRL_GO_BIT] <= 1'b0;
      if (wr_pend)
        unique case (wr_addr)
          ADDR_CTRL: ctrl <= I_HWDATA[3:0];
          ADDR_REF: ref_w <= I_HWDATA[23:0];
          ADDR_CTL: ctl_w <= I_HWDATA[23:0];
          ADDR_FB: fb_w <= I_HWDATA[23:0];
          default: ;
        endcase
    end

  // R12 dirty feedback while off
  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      fb_dirty <= 1'b1;
    else if (wr_pend && wr_addr == ADDR_FB && (!ctrl[CTRL_CHIP_EN_BIT] || ctl_w[CTL_PD_REQ_BIT]))
      fb_dirty <= 1'b1;
    else if (state == S_LATCH && tick && le && step == 2'h2)
      fb_dirty <= 1'b0;

  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
      div_cnt <= 4'h0;
    else if (state == S_IDLE || tick)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;

  always_ff @(posedge I_CLK or posedge I_RST)
    if (I_RST)
    begin
      state <= S_IDLE;
      step <= 2'h0;
      bit_cnt <= 5'h0;
      out_sh <= WORD_RESET;
      sclk <= 1'b0;
      sdat <= 1'b0;
      le <= 1'b0;
      wait_cnt <= 32'h0;
    end
    else
      unique case (state)
        S_IDLE:
          if (ctrl[CTRL_GO_BIT])
          begin
            // R13 R14 feedback-only reload when band still valid
            step <= (ctrl[CTRL_FB_ONLY_BIT] && !fb_dirty) ? 2'h2 : 2'h0;
            state <= S_LOAD;
          end
        S_LOAD:
        begin
          // R17 select never 11
          out_sh <= pick(step);
          bit_cnt <= 5'h0;
          state <= S_SHIFT;
        end
        S_SHIFT:
          if (tick)
          begin
            // R15 msb first, data set on the same clock as the rise
            if (!sclk)
            begin
              sdat <= out_sh[23];
              sclk <= 1'b1;
            end
            else
            begin
              sclk <= 1'b0;
              out_sh <= {out_sh[22:0], 1'b0};
              bit_cnt <= bit_cnt + 5'h1;
              if (bit_cnt == 5'd23)
                state <= S_LATCH;
            end
          end
        S_LATCH:
          if (tick)
          begin
            // R16 pulse load enable
            le <= ~le;
            if (le)
            begin
              // R11 settle after control
              wait_cnt <= ctrl[CTRL_SHORT_BIT] ? 32'(SETTLE_SHORT) : 32'(SETTLE_LONG);
              state <= (step == 2'h1) ? S_WAIT : S_NEXT;
            end
          end
        S_WAIT:
          if (wait_cnt <= 32'h1)
            state <= S_NEXT;
          else
            wait_cnt <= wait_cnt - 32'h1;
        S_NEXT:
          if (step == 2'h2)
            state <= S_IDLE;
          else
          begin
            step <= step + 2'h1;
            state <= S_LOAD;
          end
      endcase

  assign busy = (state != S_IDLE);
  assign LINK.serial_clk = sclk;
  assign LINK.serial_data = sdat;
  assign LINK.load_enable = le;
  assign LINK.chip_enable = ctrl[CTRL_CHIP_EN_BIT];
endmodule

/* tb/synth_latch_programming_props.sv */
`timescale 1ns/1ps
module synth_latch_programming_props
  import synth_prog_pkg::*;
#(
  parameter int SETTLE = 10
)
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_enable,
  input wire logic chip_enable
);
  logic s1, s2, le_d, le_rise;
  logic [23:0] sr;
  logic [4:0] bits;
  logic [1:0] last_sel;
  logic [9:0] gap;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Sample data mid high phase, clear of the edge
  assign le_rise = load_enable && !le_d;
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      le_d <= 1'b0;
      sr <= 24'h000000;
      bits <= 5'h00;
      last_sel <= SEL_TEST;
      gap <= 10'h3FF;
    end
    else
    begin
      s1 <= serial_clk;
      s2 <= s1;
      le_d <= load_enable;
      if (serial_clk && s1 && !s2)
      begin
        sr <= {sr[22:0], serial_data};
        bits <= bits + 5'h01;
      end
      else if (load_enable)
        bits <= 5'h00;
      if (le_rise)
        last_sel <= sr[1:0];
      if (le_rise && sr[1:0] == SEL_CONTROL)
        gap <= 10'h000;
      else if (gap != 10'h3FF)
        gap <= gap + 10'h001;
    end
  end
  property p_le_width;
    $rose(load_enable) |-> load_enable[*4] ##1 !load_enable;
  endproperty
  a_le_width: assert property (p_le_width)
    else $error("load pulse width wrong");
  property p_sclk_high;
    $rose(serial_clk) |-> serial_clk[*4] ##1 !serial_clk;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high phase wrong");
  property p_bit_count;
    le_rise |-> bits == 5'd24;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("word is not 24 bits");
  property p_no_test;
    le_rise |-> sr[1:0] != SEL_TEST;
  endproperty
  a_no_test: assert property (p_no_test)
    else $error("test latch selected");
  property p_order;
    le_rise && sr[1:0] == SEL_CONTROL |-> last_sel == SEL_REFERENCE;
  endproperty
  a_order: assert property (p_order)
    else $error("control word not after reference");
  property p_settle;
    le_rise && sr[1:0] == SEL_FEEDBACK |-> gap >= SETTLE;
  endproperty
  a_settle: assert property (p_settle)
    else $error("feedback loaded too soon");
  property p_ref_rsv;
    le_rise && sr[1:0] == SEL_REFERENCE |-> sr[23:22] == 2'h0 && !sr[19];
  endproperty
  a_ref_rsv: assert property (p_ref_rsv)
    else $error("reference reserved bits set");
  property p_fb_rsv;
    le_rise && sr[1:0] == SEL_FEEDBACK |-> !sr[7];
  endproperty
  a_fb_rsv: assert property (p_fb_rsv)
    else $error("feedback reserved bit set");
  c_fb: cover property (le_rise && sr[1:0] == SEL_FEEDBACK);
  c_ctl: cover property (le_rise && sr[1:0] == SEL_CONTROL);
  c_ce: cover property ($fell(chip_enable));
endmodule

/* tb/test_synth_latch_programming.sv */
`timescale 1ns/1ps
module test_synth_latch_programming
  import synth_prog_pkg::*;
;
  logic clk, rst, hsel, hwrite, hready, hresp, powered, gain, band, bs;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, seed;
  logic [23:0] ctl_w, ref_w, fb_w, rv, cv, fv, e;
  logic [23:0] exp_q[$];
  logic [23:0] model[3];
  int mismatches, tests_run;
  synth_link_if link();
  synth_latch_host #(.SETTLE_LONG(20), .SETTLE_SHORT(10)) i_synth_latch_host (.I_CLK(clk),
    .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .LINK(link));
  synth_latch_device i_synth_latch_device (.I_CLK(clk), .I_RST(rst), .LINK(link),
    .O_CONTROL_WORD(ctl_w), .O_REFERENCE_WORD(ref_w), .O_FEEDBACK_WORD(fb_w),
    .O_POWERED(powered), .O_PUMP_GAIN(gain), .O_BAND_SELECT(band));
  // Short settle plus one whole feedback frame, so a skipped wait shows
  synth_latch_programming_props #(.SETTLE(10 + 2 * SCLK_DIV * WORD_W))
    i_synth_latch_programming_props (.I_CLK(clk),
    .I_RST(rst), .serial_clk(link.serial_clk), .serial_data(link.serial_data),
    .load_enable(link.load_enable), .chip_enable(link.chip_enable));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string name, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, ex, got);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Poll busy with a bound; last read stays in rd
  task run(input logic [3:0] ctrl, input logic full);
    int n;
    n = 0;
    if (full)
    begin
      exp_q.push_back({2'h0, rv[21:20], 1'b0, rv[18:2], SEL_REFERENCE});
      exp_q.push_back({cv[23:2], SEL_CONTROL});
    end
    exp_q.push_back({fv[23:8], 1'b0, fv[6:2], SEL_FEEDBACK});
    bus(1'b1, ADDR_CTRL, {28'h0, ctrl});
    repeat (4) @(posedge clk);
    rd = 32'h1;
    while (rd[0] && n < 1000)
    begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    // A sequence that never ends is a failure
    if (rd[0])
    begin
      mismatches++;
      conclude;
    end
  endtask
  // Each load: pop the note, compare all three held words
  always @(posedge link.load_enable)
  begin
    repeat (2) @(posedge clk);
    bs = band;
    @(posedge clk);
    e = exp_q.pop_front();
    model[e[1:0]] = e;
    check("control", model[0], ctl_w);
    check("reference", model[1], ref_w);
    check("feedback", model[2], fb_w);
    check("band_select", {31'h0, e[1:0] == SEL_FEEDBACK}, {31'h0, bs});
  end
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches++;
    conclude;
  end
  initial
  begin
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seed = 32'h0BF4;
    model = '{24'h0, 24'h0, 24'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status_reset", 32'h2, rd);
    check("powered_reset", 32'h0, {31'h0, powered});
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rd);
    check("okay_resp", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      rv = seed[23:0];
      seed = lfsr(seed);
      cv = seed[23:0] & 24'hCFFFFF;
      seed = lfsr(seed);
      fv = seed[23:0];
      bus(1'b1, ADDR_REF, {8'h00, rv});
      bus(1'b1, ADDR_CTL, {8'h00, cv});
      bus(1'b1, ADDR_FB, {8'h00, fv});
      run({2'h1, i[0], 1'b1}, 1'b1);
      check("powered", 32'h1, {31'h0, powered});
      check("gain", {31'h0, fv[21]}, {31'h0, gain});
    end
    // Clean feedback: only the feedback word goes out
    fv = ~fv;
    bus(1'b1, ADDR_FB, {8'h00, fv});
    run(4'hD, 1'b0);
    check("status_fb_only", 32'h0, rd);
    // Feedback changed while chip disabled forces a full sequence
    bus(1'b1, ADDR_CTRL, 32'h0);
    @(negedge clk);
    check("chip_off", 32'h0, {31'h0, link.chip_enable});
    seed = lfsr(seed);
    fv = seed[23:0];
    bus(1'b1, ADDR_FB, {8'h00, fv});
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("dirty", 32'h2, rd & 32'h2);
    run(4'hD, 1'b1);
    check("status_clean", 32'h0, rd);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h4);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("ce_cycle", 32'h0, rd);
    check("ce_powered", 32'h1, {31'h0, powered});
    check("pending", 32'h0, 32'(exp_q.size()));
    conclude;
  end
endmodule
